// ---- verilog/asc_pkg.sv ----
// Purpose: Constants and types for the converter sequencing control block
// Assumes: APB byte address is four times the register index
// Notes: Control registers sit in the low byte of each word, result and window limits in the low half; upper bits read zero
//
// Contract
// - Standby-run clear: stop in standby, but only after the running conversion.
// - Conversion type 0 single-ended unsigned; 1 differential signed result.
// - Left-align bit set presents the result left-justified; the code left-justifies only with accumulation code 0.
// - Resolution code 0 gives 12-bit, code 1 gives 10-bit, others reserved.
// - Conversion lasts 13.5 converter cycles at 12-bit, 11.5 at 10-bit.
// - Continuous mode runs back to back; software starts the first with go.
// - Enable bit 0 turns the converter off when 0, on when 1.
// - Accumulation code 0 none; codes 1..7 add 2 to 128 results.
// - Prescaler codes 0..13 divide the peripheral clock by 2 to 256.
// - Startup delay before first sample after enable or reference change.
// - Startup delay codes 0..5 give 0,16,32,64,128,256 converter cycles.
// - Startup delay also applies on wake from deep sleep.
// - Gap between consecutive samples equals the gap field, 0 to 15 cycles.
// - Window mode: off, below, above, inside inclusive, outside; others reserved.
// - Window compares the 16-bit accumulated result against 16-bit limits.
// - Sampling lasts two cycles plus the sample-extend field.
// - Go bit reads 1 during conversion and clears itself on completion.
// - Result-done flag sets when a measurement completes.
// - Window compare happens only at conversion end; sets match flag.
package asc_pkg;
    // ========================================
    // Register indices
    localparam logic [4:0] IDX_MAIN = 5'h00;
    localparam logic [4:0] IDX_ACCUM = 5'h01;
    localparam logic [4:0] IDX_CLOCK_DIVIDER = 5'h02;
    localparam logic [4:0] IDX_DELAY = 5'h03;
    localparam logic [4:0] IDX_WINDOW = 5'h04;
    localparam logic [4:0] IDX_SAMPLE_EXTEND = 5'h05;
    localparam logic [4:0] IDX_CMD = 5'h0A;
    localparam logic [4:0] IDX_FLAGS = 5'h0D;
    localparam logic [4:0] IDX_RESULT = 5'h10;
    localparam logic [4:0] IDX_WIN_LO = 5'h12;
    localparam logic [4:0] IDX_WIN_HI = 5'h14;
    // ========================================
    // Writable masks and reset values
    localparam logic [7:0] MASK_MAIN = 8'hBF;
    localparam logic [7:0] MASK_ACCUM = 8'h07;
    localparam logic [7:0] MASK_CLOCK_DIVIDER = 8'h0F;
    localparam logic [7:0] MASK_DELAY = 8'hEF;
    localparam logic [7:0] MASK_WINDOW = 8'h07;
    localparam logic [7:0] RST_CTRL = 8'h00;
    // ========================================
    // Field positions
    localparam int MAIN_EN = 0;
    localparam int MAIN_FREE = 1;
    localparam int MAIN_RES = 2;
    localparam int MAIN_LALIGN = 4;
    localparam int MAIN_DIFFERENTIAL_INPUT = 5;
    localparam int MAIN_STBY = 7;
    localparam int CMD_GO = 0;
    localparam int CMD_STOP = 1;
    localparam int FLG_DONE = 0;
    localparam int FLG_WIN = 1;
    localparam int DLY_INIT = 5;
    // ========================================
    // Conversion timing in converter half cycles, sample base in whole cycles
    localparam logic [9:0] CONV_HALF_12 = 10'h01B;
    localparam logic [9:0] CONV_HALF_10 = 10'h017;
    localparam logic [9:0] SAMP_BASE = 10'h002;
    // ========================================
    // Window modes
    localparam logic [2:0] WIN_BELOW = 3'h1;
    localparam logic [2:0] WIN_ABOVE = 3'h2;
    localparam logic [2:0] WIN_INSIDE = 3'h3;
    localparam logic [2:0] WIN_OUTSIDE = 3'h4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_INIT = 3'b001,
        ST_SAMP = 3'b010,
        ST_CONV = 3'b011,
        ST_GAP = 3'b100
    } asc_state_e;
endpackage

// ---- verilog/asc_div_if.sv ----
// Purpose: Link between sequencer and converter clock divider
// Assumes: Single clock domain
// Notes: Half tick marks every edge of the converter clock
`timescale 1ns/1ps
interface asc_div_if;
    logic [3:0] div_sel;
    logic run;
    logic half_tick;
    logic adc_clk;
    modport seq (output div_sel, output run, input half_tick, input adc_clk);
    modport div (input div_sel, input run, output half_tick, output adc_clk);
endinterface

// ---- verilog/asc_clkdiv.sv ----
// Purpose: Converter clock prescaler
// Assumes: Divider code arrives from the sequencer registers
// Notes: Clock held low while not running
`timescale 1ns/1ps
module asc_clkdiv (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    asc_div_if.div dv
);
    import asc_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
        logic clk;
    } asc_div_s;

    asc_div_s q, d;

    // Half period in peripheral clocks, reserved codes act as divide by 2
    function automatic logic [7:0] half_period(input logic [3:0] c);
        case (c)
            4'h1: half_period = 8'h02;
            4'h2: half_period = 8'h04;
            4'h3: half_period = 8'h06;
            4'h4: half_period = 8'h08;
            4'h5: half_period = 8'h0A;
            4'h6: half_period = 8'h0C;
            4'h7: half_period = 8'h0E;
            4'h8: half_period = 8'h10;
            4'h9: half_period = 8'h18;
            4'hA: half_period = 8'h20;
            4'hB: half_period = 8'h30;
            4'hC: half_period = 8'h40;
            4'hD: half_period = 8'h80;
            default: half_period = 8'h01;
        endcase
    endfunction

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (!dv.run) begin
            d.cnt = 8'h00;
            d.clk = 1'b0;
        end else if (q.cnt + 8'h01 >= half_period(dv.div_sel)) begin
            d.cnt = 8'h00;
            d.tick = 1'b1;
            d.clk = !q.clk;
        end else begin
            d.cnt = q.cnt + 8'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dv.half_tick = q.tick;
    assign dv.adc_clk = q.clk;
endmodule // asc_clkdiv

// ---- verilog/asc_top.sv ----
// Purpose: Converter sequencing control with APB register file
// Assumes: Analog core supplies a 12-bit sample, two's complement in differential mode
// Notes: Sequencer timing counts converter half cycles
`timescale 1ns/1ps
module asc_top (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic standby_i,
    input wire logic deep_wake_i,
    input wire logic ref_change_i,
    input wire logic [11:0] sample_data_i,
    output logic adc_clk_o,
    output logic adc_on_o,
    output logic sample_hold_o,
    output logic conv_busy_o,
    output logic differential_input_mode_o
);
    import asc_pkg::*;

    typedef struct packed {
        logic [7:0] main;
        logic [7:0] accum;
        logic [7:0] clock_divider;
        logic [7:0] dly;
        logic [7:0] win;
        logic [7:0] samp;
        logic [15:0] wlo;
        logic [15:0] whi;
        logic [15:0] res;
        logic go;
        logic free_run;
        logic f_done;
        logic f_win;
        logic need_init;
        logic en_d;
        asc_state_e st;
        logic [9:0] cnt;
        logic [7:0] nacc;
        logic [19:0] acc;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [2:0] stby_s;
        logic [2:0] wake_s;
        logic [2:0] ref_s;
        logic [11:0] dat1;
        logic [11:0] dat2;
        logic busy;
        logic hold;
        logic on;
    } asc_top_s;

    asc_top_s q, d;
    asc_div_if dv();
    logic [4:0] idx;
    logic wr;
    logic rd;
    logic go_wr;
    logic meas_done;
    logic stby_stop;
    logic res10;
    logic [19:0] acc_n;
    logic [15:0] res_n;

    asc_clkdiv u_div (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .dv(dv)
    );

    // ========================================
    // Decode helpers
    function automatic logic [9:0] init_half(input logic [2:0] c);
        case (c)
            3'h1: init_half = 10'h020;
            3'h2: init_half = 10'h040;
            3'h3: init_half = 10'h080;
            3'h4: init_half = 10'h100;
            3'h5: init_half = 10'h200;
            default: init_half = 10'h000;
        endcase
    endfunction

    function automatic logic [19:0] sample_ext(input logic [11:0] s, input logic r10, input logic sgn);
        logic [11:0] v;
        v = r10 ? {{2{sgn & s[11]}}, s[11:2]} : s;
        sample_ext = {{8{sgn & v[11]}}, v};
    endfunction

    function automatic logic win_hit(input logic [2:0] m, input logic [15:0] r,
                                     input logic [15:0] lo, input logic [15:0] hi, input logic sgn);
        logic below;
        logic above;
        below = sgn ? ($signed(r) < $signed(lo)) : (r < lo);
        above = sgn ? ($signed(r) > $signed(hi)) : (r > hi);
        case (m)
            WIN_BELOW: win_hit = below;
            WIN_ABOVE: win_hit = above;
            WIN_INSIDE: win_hit = !below && !above;
            WIN_OUTSIDE: win_hit = below || above;
            default: win_hit = 1'b0;
        endcase
    endfunction

    // ========================================
    // Register file and sequencer
    always_comb begin
        d = q;
        idx = paddr_i[6:2];
        wr = psel_i && penable_i && pwrite_i && q.pready;
        rd = psel_i && penable_i && !pwrite_i && q.pready;
        go_wr = 1'b0;
        meas_done = 1'b0;
        res10 = q.main[MAIN_RES +: 2] == 2'b01;
        stby_stop = q.stby_s[1] && !q.main[MAIN_STBY];
        acc_n = q.acc + sample_ext(q.dat2, res10, q.main[MAIN_DIFFERENTIAL_INPUT]);
        res_n = acc_n[15:0];
        if (q.accum[2:0] == 3'h0 && q.main[MAIN_LALIGN]) begin
            res_n = res10 ? {acc_n[9:0], 6'h00} : {acc_n[11:0], 4'h0};
        end

        // Pin inputs pass two flops; the third only feeds edge detection
        d.stby_s = {q.stby_s[1:0], standby_i};
        d.wake_s = {q.wake_s[1:0], deep_wake_i};
        d.ref_s = {q.ref_s[1:0], ref_change_i};
        d.dat1 = sample_data_i;
        d.dat2 = q.dat1;

        // One wait state keeps every APB output on a flop
        d.pready = psel_i && penable_i && !q.pready;
        if (psel_i && penable_i && !q.pready) begin
            d.pslverr = 1'b0;
            case (idx)
                IDX_MAIN: d.prdata = {24'h0, q.main};
                IDX_ACCUM: d.prdata = {24'h0, q.accum};
                IDX_CLOCK_DIVIDER: d.prdata = {24'h0, q.clock_divider};
                IDX_DELAY: d.prdata = {24'h0, q.dly};
                IDX_WINDOW: d.prdata = {24'h0, q.win};
                IDX_SAMPLE_EXTEND: d.prdata = {24'h0, q.samp};
                IDX_CMD: d.prdata = {31'h0, q.go};
                IDX_FLAGS: d.prdata = {30'h0, q.f_win, q.f_done};
                IDX_RESULT: d.prdata = {16'h0, q.res};
                IDX_WIN_LO: d.prdata = {16'h0, q.wlo};
                IDX_WIN_HI: d.prdata = {16'h0, q.whi};
                default: begin
                    d.prdata = 32'h0;
                    d.pslverr = 1'b1;
                end
            endcase
        end

        // Reading the result clears both flags
        if (rd && idx == IDX_RESULT) begin
            d.f_done = 1'b0;
            d.f_win = 1'b0;
        end
        if (wr) begin
            case (idx)
                IDX_MAIN: d.main = pwdata_i[7:0] & MASK_MAIN;
                IDX_ACCUM: d.accum = pwdata_i[7:0] & MASK_ACCUM;
                IDX_CLOCK_DIVIDER: d.clock_divider = pwdata_i[7:0] & MASK_CLOCK_DIVIDER;
                IDX_DELAY: d.dly = pwdata_i[7:0] & MASK_DELAY;
                IDX_WINDOW: d.win = pwdata_i[7:0] & MASK_WINDOW;
                IDX_SAMPLE_EXTEND: d.samp = pwdata_i[7:0];
                IDX_WIN_LO: d.wlo = pwdata_i[15:0];
                IDX_WIN_HI: d.whi = pwdata_i[15:0];
                IDX_FLAGS: begin
                    if (pwdata_i[FLG_DONE]) begin
                        d.f_done = 1'b0;
                    end
                    if (pwdata_i[FLG_WIN]) begin
                        d.f_win = 1'b0;
                    end
                end
                IDX_CMD: go_wr = pwdata_i[CMD_GO] && !pwdata_i[CMD_STOP];
                default: d.main = q.main;
            endcase
        end

        // Startup delay is owed after enable, reference change or deep-sleep wake
        d.en_d = q.main[MAIN_EN];
        if ((q.main[MAIN_EN] && !q.en_d) || (q.ref_s[1] && !q.ref_s[2])) begin
            d.need_init = 1'b1;
        end
        if (q.wake_s[1] && !q.wake_s[2]) begin
            d.need_init = 1'b1;
        end
        if (!q.main[MAIN_FREE]) begin
            d.free_run = 1'b0;
        end

        unique case (q.st)
            ST_IDLE: begin
                if ((q.go || q.free_run) && q.main[MAIN_EN] && !stby_stop) begin
                    d.acc = 20'h0;
                    d.nacc = 8'h00;
                    d.need_init = 1'b0;
                    if (q.need_init && init_half(q.dly[DLY_INIT +: 3]) != 10'h0) begin
                        d.st = ST_INIT;
                        d.cnt = init_half(q.dly[DLY_INIT +: 3]) - 10'h001;
                    end else begin
                        d.st = ST_SAMP;
                        d.cnt = ((SAMP_BASE + {2'b00, q.samp}) << 1) - 10'h001;
                    end
                end
            end
            ST_INIT, ST_GAP: begin
                if (dv.half_tick) begin
                    if (q.cnt == 10'h0) begin
                        d.st = ST_SAMP;
                        d.cnt = ((SAMP_BASE + {2'b00, q.samp}) << 1) - 10'h001;
                    end else begin
                        d.cnt = q.cnt - 10'h001;
                    end
                end
            end
            ST_SAMP: begin
                if (dv.half_tick) begin
                    if (q.cnt == 10'h0) begin
                        d.st = ST_CONV;
                        d.cnt = (res10 ? CONV_HALF_10 : CONV_HALF_12) - 10'h001;
                    end else begin
                        d.cnt = q.cnt - 10'h001;
                    end
                end
            end
            ST_CONV: begin
                if (dv.half_tick) begin
                    if (q.cnt == 10'h0) begin
                        d.acc = acc_n;
                        d.nacc = q.nacc + 8'h01;
                        if ((q.nacc + 8'h01) == (8'h01 << q.accum[2:0])) begin
                            meas_done = 1'b1;
                            d.acc = 20'h0;
                            d.nacc = 8'h00;
                            d.res = res_n;
                            d.go = 1'b0;
                        end
                        if (!meas_done || (q.free_run && !stby_stop)) begin
                            d.st = (q.dly[3:0] == 4'h0) ? ST_SAMP : ST_GAP;
                            d.cnt = (q.dly[3:0] == 4'h0) ? ((SAMP_BASE + {2'b00, q.samp}) << 1) - 10'h001
                                                         : {5'h00, q.dly[3:0], 1'b0} - 10'h001;
                        end else begin
                            d.st = ST_IDLE;
                        end
                    end else begin
                        d.cnt = q.cnt - 10'h001;
                    end
                end
            end
        endcase

        // Flags: a completion in the same cycle as a clear wins
        if (meas_done) begin
            d.f_done = 1'b1;
            if (win_hit(q.win[2:0], res_n, q.wlo, q.whi, q.main[MAIN_DIFFERENTIAL_INPUT])) begin
                d.f_win = 1'b1;
            end
        end
        if (go_wr) begin
            d.go = 1'b1;
            d.free_run = q.main[MAIN_FREE];
        end
        // Stop and disable abort the sequence at once
        if ((wr && idx == IDX_CMD && pwdata_i[CMD_STOP]) || !q.main[MAIN_EN]) begin
            d.st = ST_IDLE;
            d.go = 1'b0;
            d.free_run = 1'b0;
            d.acc = 20'h0;
            d.nacc = 8'h00;
        end

        d.busy = d.st != ST_IDLE;
        d.hold = d.st == ST_SAMP;
        d.on = d.main[MAIN_EN] && !(stby_stop && d.st == ST_IDLE);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dv.div_sel = q.clock_divider[3:0];
    assign dv.run = q.main[MAIN_EN];
    assign prdata_o = q.prdata;
    assign pready_o = q.pready;
    assign pslverr_o = q.pslverr;
    assign adc_clk_o = dv.adc_clk;
    assign adc_on_o = q.on;
    assign sample_hold_o = q.hold;
    assign conv_busy_o = q.busy;
    assign differential_input_mode_o = q.main[MAIN_DIFFERENTIAL_INPUT];

    // ========================================
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    go_clears_a: assert property (meas_done && !go_wr |=> !q.go) else $error("go not cleared");
    done_sets_a: assert property (meas_done |=> q.f_done) else $error("done flag missing");
    off_idle_a: assert property (!q.main[MAIN_EN] |=> q.st == ST_IDLE && !q.busy) else $error("runs while off");
    init_first_a: assert property ($rose(q.st == ST_SAMP) && $past(q.st) == ST_IDLE
        |-> !$past(q.need_init) || init_half($past(q.dly[7:5])) == 10'h000) else $error("startup delay skipped");
    conv_len_a: assert property ($rose(q.st == ST_CONV)
        |-> q.cnt == ($past(res10) ? CONV_HALF_10 : CONV_HALF_12) - 10'h001) else $error("conversion length");
    samp_len_a: assert property ($rose(q.st == ST_SAMP)
        |-> q.cnt == (({2'b00, $past(q.samp)} + 10'h002) << 1) - 10'h001) else $error("sample length");
    gap_len_a: assert property ($rose(q.st == ST_GAP)
        |-> q.cnt == {5'h00, $past(q.dly[3:0]), 1'b0} - 10'h001) else $error("gap length");
    win_end_a: assert property ($rose(q.f_win) |-> $past(meas_done)) else $error("window off conversion end");
    standby_a: assert property (q.st == ST_IDLE && stby_stop |=> q.st == ST_IDLE) else $error("ran in standby");

    // ========================================
    // Start and output checks
    sequence go_taken_s;
        q.st == ST_IDLE && q.go && q.main[MAIN_EN] && !stby_stop && !wr;
    endsequence

    sequence seq_running_s;
        q.busy && q.st != ST_IDLE;
    endsequence

    // A lost start would leave software polling the go bit forever
    start_a: assert property (go_taken_s |=> seq_running_s) else $error("start lost");
    init_len_a: assert property ($rose(q.st == ST_INIT)
        |-> q.cnt == init_half($past(q.dly[7:5])) - 10'h001) else $error("startup length");
    res_load_a: assert property (meas_done |=> q.res == $past(res_n)) else $error("result lost");
    win_off_a: assert property (q.win[2:0] == 3'h0 |=> !$rose(q.f_win)) else $error("window while off");
    clk_off_a: assert property (!q.main[MAIN_EN] |=> !adc_clk_o) else $error("clock while off");
    stby_off_a: assert property (q.st == ST_IDLE && stby_stop |=> !q.on) else $error("on in standby");
    // Ready must drop after one cycle or a waiting master takes a second transfer
    ready_pulse_a: assert property (q.pready |=> !q.pready) else $error("ready stretched");
endmodule // asc_top

// ---- bench/adc_sequencing_control_tb.sv ----
// Purpose: Self-checking bench for the converter sequencing control
// Assumes: Prescaler code 0 outside its own loop, so one half tick is one clock
// Notes: Busy lengths are compared with the first plain conversion, whose overhead is unknown
`timescale 1ns/1ps
module adc_sequencing_control_tb;
    import asc_pkg::*;
    logic clk;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic stby = 1'b0;
    logic wake = 1'b0;
    logic refc = 1'b0;
    logic [11:0] smp = 12'h000;
    logic [15:0] lf = 16'h0004;
    logic [31:0] prdata, rdv, flg;
    logic pready, pslverr, perr, aclk, aon, shold, busy, dmode;
    int errors, compares, base, bcnt, p;
    bit watch_on, have_base;
    int dq[$];

    asc_top dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .standby_i(stby), .deep_wake_i(wake),
        .ref_change_i(refc), .sample_data_i(smp), .adc_clk_o(aclk), .adc_on_o(aon),
        .sample_hold_o(shold), .conv_busy_o(busy), .differential_input_mode_o(dmode));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ========================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int divof(input int c);
        int t[14] = '{2, 4, 8, 12, 16, 20, 24, 28, 32, 48, 64, 96, 128, 256};
        return (c < 14) ? t[c] : 2;
    endfunction
    function automatic logic wexp(input int m, input int r);
        case (m)
            1: return r < 256;
            2: return r > 512;
            3: return r >= 256 && r <= 512;
            4: return r < 256 || r > 512;
            default: return 1'b0;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Called just after an edge; ends one idle edge after the answer
    task automatic apb(input logic w, input logic [4:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) errors++;
        rdv = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask
    task automatic rd(input logic [4:0] idx, input logic [31:0] exp, input string nm);
        apb(1'b0, idx, 32'h0);
        chk(nm, rdv, exp);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 30000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 30000) errors++;
        @(posedge clk);
    endtask
    // Expected busy length goes on the queue before the go is written
    task automatic conv(input int exp, input logic sb);
        if (watch_on) dq.push_back(exp);
        wr(IDX_CMD, 32'h1);
        if (sb) stby <= 1'b1;
        rd(IDX_CMD, 32'h1, "go_busy");
        wait_idle();
        rd(IDX_CMD, 32'h0, "go_done");
        apb(1'b0, IDX_FLAGS, 32'h0);
        flg = rdv;
        chk("done_flag", flg[0], 1'b1);
    endtask
    task automatic per(output int pd);
        int n, t0, e;
        logic pv;
        n = 0;
        e = 0;
        t0 = 0;
        pv = aclk;
        while (e < 2 && n < 3000) begin
            @(posedge clk);
            n++;
            if (aclk === 1'b1 && pv === 1'b0) begin
                e++;
                if (e == 1) t0 = n;
            end
            pv = aclk;
        end
        pd = n - t0;
    endtask
    task automatic reen(input logic [31:0] d);
        wr(IDX_DELAY, d);
        wr(IDX_MAIN, 32'h0);
        wr(IDX_MAIN, 32'h1);
    endtask

    // ========================================
    // Watcher: takes the oldest noted length at each end of busy
    always @(posedge clk) begin
        if (busy === 1'b1) begin
            bcnt++;
        end else if (bcnt != 0) begin
            if (watch_on && !have_base) begin
                base = bcnt;
                have_base = 1'b1;
            end
            if (watch_on && dq.size() > 0) chk("busy_len", 32'(bcnt - base), 32'(dq.pop_front()));
            bcnt = 0;
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        end_sim();
    end

    // ========================================
    // Main sequence
    initial begin
        logic [7:0] msk[6];
        logic [11:0] wv[4];
        msk = '{MASK_MAIN, MASK_ACCUM, MASK_CLOCK_DIVIDER, MASK_DELAY, MASK_WINDOW, 8'hFF};
        wv = '{12'h0FF, 12'h100, 12'h200, 12'h201};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rd(5'(i), {24'h0, RST_CTRL}, "ctrl_reset");
            wr(5'(i), 32'hFFFFFFFF);
            rd(5'(i), {24'h0, msk[i]}, "ctrl_mask");
            wr(5'(i), 32'h0);
        end
        apb(1'b0, 5'h1F, 32'h0);
        chk("unmapped_err", perr, 1'b1);
        chk("unmapped_data", rdv, 32'h0);
        wr(IDX_MAIN, 32'h01);
        repeat (3) @(posedge clk);
        chk("adc_on", aon, 1'b1);
        watch_on = 1'b1;
        lf = lfsr(lf);
        smp <= lf[11:0];
        conv(0, 1'b0);
        rd(IDX_RESULT, {20'h0, lf[11:0]}, "res_plain");
        wr(IDX_MAIN, 32'h11);
        conv(0, 1'b0);
        rd(IDX_RESULT, {16'h0, lf[11:0], 4'h0}, "res_left");
        wr(IDX_MAIN, 32'h05);
        conv(-4, 1'b0);
        rd(IDX_RESULT, {22'h0, lf[11:2]}, "res_10b");
        wr(IDX_MAIN, 32'h09);
        conv(0, 1'b0);
        rd(IDX_RESULT, {20'h0, lf[11:0]}, "res_rsv");
        wr(IDX_MAIN, 32'h01);
        wr(IDX_SAMPLE_EXTEND, 32'h03);
        conv(6, 1'b0);
        wr(IDX_SAMPLE_EXTEND, 32'hFF);
        conv(510, 1'b0);
        wr(IDX_SAMPLE_EXTEND, 32'h0);
        wr(IDX_ACCUM, 32'h1);
        conv(31, 1'b0);
        rd(IDX_RESULT, {19'h0, lf[11:0], 1'b0}, "res_acc2");
        wr(IDX_DELAY, 32'h0F);
        conv(61, 1'b0);
        wr(IDX_DELAY, 32'h0);
        wr(IDX_ACCUM, 32'h7);
        conv(3937, 1'b0);
        rd(IDX_RESULT, {16'h0, lf[8:0], 7'h0}, "res_acc128");
        wr(IDX_ACCUM, 32'h0);
        reen(32'h20);
        conv(32, 1'b0);
        conv(0, 1'b0);
        wake <= 1'b1;
        repeat (4) @(posedge clk);
        wake <= 1'b0;
        conv(32, 1'b0);
        refc <= 1'b1;
        repeat (4) @(posedge clk);
        refc <= 1'b0;
        conv(32, 1'b0);
        reen(32'hA0);
        conv(512, 1'b0);
        reen(32'hE0);
        conv(0, 1'b0);
        wr(IDX_DELAY, 32'h0);
        wr(IDX_MAIN, 32'h21);
        smp <= 12'hF00;
        conv(0, 1'b0);
        chk("differential_input_pin", dmode, 1'b1);
        rd(IDX_RESULT, 32'h0000FF00, "res_signed");
        wr(IDX_MAIN, 32'h01);
        wr(IDX_WIN_LO, 32'h100);
        wr(IDX_WIN_HI, 32'h200);
        for (int m = 0; m < 5; m++) begin
            wr(IDX_WINDOW, 32'(m));
            foreach (wv[k]) begin
                smp <= wv[k];
                conv(0, 1'b0);
                chk("win_flag", flg[1], wexp(m, wv[k]));
                rd(IDX_RESULT, {20'h0, wv[k]}, "res_win");
            end
        end
        wr(IDX_WINDOW, 32'h0);
        chk("len_queue", dq.size(), 0);
        // Lengths below are not noted, standby and free-run change them
        watch_on = 1'b0;
        conv(0, 1'b1);
        apb(1'b0, IDX_RESULT, 32'h0);
        wr(IDX_CMD, 32'h1);
        repeat (60) @(posedge clk);
        chk("stby_idle", busy, 1'b0);
        wr(IDX_MAIN, 32'h0);
        wr(IDX_MAIN, 32'h81);
        conv(0, 1'b0);
        wr(IDX_FLAGS, 32'h3);
        rd(IDX_FLAGS, 32'h0, "flag_w1c");
        stby <= 1'b0;
        wr(IDX_SAMPLE_EXTEND, 32'h10);
        wr(IDX_MAIN, 32'h03);
        wr(IDX_CMD, 32'h1);
        repeat (4) @(posedge clk);
        chk("hold_pin", shold, 1'b1);
        rd(IDX_CMD, 32'h1, "go_busy");
        repeat (100) @(posedge clk);
        rd(IDX_CMD, 32'h0, "go_done");
        apb(1'b0, IDX_FLAGS, 32'h0);
        chk("done_flag", rdv[0], 1'b1);
        chk("free_rerun", busy, 1'b1);
        wr(IDX_CMD, 32'h2);
        wr(IDX_MAIN, 32'h01);
        wr(IDX_SAMPLE_EXTEND, 32'h0);
        repeat (80) @(posedge clk);
        chk("free_stop", busy, 1'b0);
        for (int c = 0; c < 16; c++) begin
            wr(IDX_CLOCK_DIVIDER, 32'(c));
            wr(IDX_CMD, 32'h1);
            per(p);
            chk("adc_clk_div", 32'(p), 32'(divof(c)));
            wait_idle();
        end
        end_sim();
    end
endmodule // adc_sequencing_control_tb
